/* File: rtl/ppc_port_cfg.sv */
// Top: port 0 and port 1 configuration registers and port 1 data register on the SPECIAL_FUNCTION_REGISTER bus
//
// Functional notes
// R1 - Analog mode disables pull-up and digital receiver
// R2 - Input-mode bit 0 analog, 1 digital
// R3 - Software sets open-drain for analog pins
// R4 - Output-mode bit 0 open-drain, 1 push-pull
// R5 - Output-mode bit ignored while pin analog
// R6 - Skip bit 1 makes crossbar pass pin
// R7 - Software skips pins used for other functions
// R8 - Data write loads latch, 0 low 1 high
// R9 - Data read returns digital pin levels
// R10 - Bits 7..0 control pins 7..0
// R11 - Configuration registers only on page 0x0F
// R12 - Data register on all pages, bit-addressable
// R13 - Read-modify-write reads latch, not pins
// R14 - Bus pins forced open-drain always (code forces them only while bus_pins_active)
// R15 - Open-drain drives low only; push-pull both
`timescale 1ns/100ps
module ppc_port_cfg
  import ppc_pkg::*;
#(
  parameter int          WIDTH   = 8,
  parameter logic [7:0]  OD_MASK0 = 8'h00,
  parameter logic [7:0]  OD_MASK1 = 8'h00
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Special function register bus
  input  wire logic [7:0]       sfr_page,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  input  wire logic             sfr_bit_acc,
  input  wire logic [2:0]       sfr_bit_idx,
  input  wire logic             sfr_rmw,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  output logic                  sfr_hit,
  // Bus pin force (two-wire bus active)
  input  wire logic             bus_pins_active,
  // Port 0 pads
  input  wire logic [WIDTH-1:0] port0_pin_in,
  input  wire logic [WIDTH-1:0] port0_periph_out,
  output logic      [WIDTH-1:0] port0_pin_out,
  output logic      [WIDTH-1:0] port0_pin_oe,
  output logic      [WIDTH-1:0] port0_pullup_en,
  output logic      [WIDTH-1:0] port0_rx_en,
  output logic      [WIDTH-1:0] port0_pin_level,
  // Port 1 pads
  input  wire logic [WIDTH-1:0] port1_pin_in,
  output logic      [WIDTH-1:0] port1_pin_out,
  output logic      [WIDTH-1:0] port1_pin_oe,
  output logic      [WIDTH-1:0] port1_pullup_en,
  output logic      [WIDTH-1:0] port1_rx_en,
  // Crossbar
  output logic      [WIDTH-1:0] port0_crossbar_skip
);
  logic [7:0] port1_data_latch_ff;
  logic [7:0] port0_output_drive_select_ff;
  logic [7:0] port1_output_drive_select_ff;
  logic [7:0] port0_crossbar_bypass_ff;
  logic [7:0] port0_analog_digital_select_ff;
  logic [7:0] port1_analog_digital_select_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] nxt_p1_latch;

  wire [WIDTH-1:0] p0_sync;
  wire [WIDTH-1:0] p1_sync;
  wire [WIDTH-1:0] p0_dig;
  wire [WIDTH-1:0] p1_dig;

  initial begin
    if (WIDTH != 8) $error("ppc_port_cfg: WIDTH must be 8");
  end

  function automatic logic [7:0] bit_merge(input logic [7:0] old_v, input logic [2:0] idx,
                                           input logic val);
    logic [7:0] r;
    r      = old_v;
    r[idx] = val;
    return r;
  endfunction

  // Address decode
  wire cfg_page  = (sfr_page == PPC_CFG_PAGE);                         // [R11]
  wire hit_data  = (sfr_addr == PPC_ADDR_P1DATA);                      // [R12]
  wire hit_p0drv = cfg_page && (sfr_addr == PPC_ADDR_P0DRV);           // [R11]
  wire hit_p1drv = cfg_page && (sfr_addr == PPC_ADDR_P1DRV);           // [R11]
  wire hit_p0byp = cfg_page && (sfr_addr == PPC_ADDR_P0BYP);           // [R11]
  wire hit_p0ana = cfg_page && (sfr_addr == PPC_ADDR_P0ANA);           // [R11]
  wire hit_p1ana = cfg_page && (sfr_addr == PPC_ADDR_P1ANA);           // [R11]
  wire any_hit   = hit_data | hit_p0drv | hit_p1drv | hit_p0byp | hit_p0ana | hit_p1ana;

  wire wr_data  = sfr_wr && hit_data;
  wire wr_p0drv = sfr_wr && hit_p0drv;
  wire wr_p1drv = sfr_wr && hit_p1drv;
  wire wr_p0byp = sfr_wr && hit_p0byp;
  wire wr_p0ana = sfr_wr && hit_p0ana;
  wire wr_p1ana = sfr_wr && hit_p1ana;

  // Data read source: latch for read-modify-write, pins otherwise
  wire [7:0] p1_read_src = sfr_rmw ? port1_data_latch_ff : p1_dig;    // [R13] [R9]

  // Bit or byte update of the data latch
  assign nxt_p1_latch = sfr_bit_acc
                      ? bit_merge(port1_data_latch_ff, sfr_bit_idx, sfr_wdata[0])
                      : sfr_wdata;                                     // [R8] [R12]

  // Read multiplexer
  always_comb begin
    nxt_rdata = 8'h00;
    case (1'b1)
      hit_data:  nxt_rdata = sfr_bit_acc ? {7'h00, p1_read_src[sfr_bit_idx]}
                                         : p1_read_src;               // [R12]
      hit_p0drv: nxt_rdata = port0_output_drive_select_ff;
      hit_p1drv: nxt_rdata = port1_output_drive_select_ff;
      hit_p0byp: nxt_rdata = port0_crossbar_bypass_ff;
      hit_p0ana: nxt_rdata = port0_analog_digital_select_ff;
      hit_p1ana: nxt_rdata = port1_analog_digital_select_ff;
      default:   nxt_rdata = 8'h00;
    endcase
  end

  // Register file
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_data_latch_ff            <= PPC_RST_P1DATA;
      port0_output_drive_select_ff   <= PPC_RST_DRV;
      port1_output_drive_select_ff   <= PPC_RST_DRV;
      port0_crossbar_bypass_ff       <= PPC_RST_BYP;
      port0_analog_digital_select_ff <= PPC_RST_ANA;
      port1_analog_digital_select_ff <= PPC_RST_ANA;
    end else begin
      if (wr_data)  port1_data_latch_ff            <= nxt_p1_latch;    // [R8]
      if (wr_p0drv) port0_output_drive_select_ff   <= sfr_wdata;       // [R10]
      if (wr_p1drv) port1_output_drive_select_ff   <= sfr_wdata;       // [R10]
      if (wr_p0byp) port0_crossbar_bypass_ff       <= sfr_wdata;       // [R10]
      if (wr_p0ana) port0_analog_digital_select_ff <= sfr_wdata;       // [R10]
      if (wr_p1ana) port1_analog_digital_select_ff <= sfr_wdata;       // [R10]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (sfr_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign sfr_hit   = any_hit;

  // Pin synchronisers
  ppc_pin_sync #(.WIDTH(WIDTH)) u_sync0 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_async (port0_pin_in),
    .pin_level (p0_sync)
  );

  ppc_pin_sync #(.WIDTH(WIDTH)) u_sync1 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_async (port1_pin_in),
    .pin_level (p1_sync)
  );

  // Bus pins forced open-drain while the two-wire bus owns them
  wire [WIDTH-1:0] p0_force_od = bus_pins_active ? OD_MASK0 : '0;     // [R14]
  wire [WIDTH-1:0] p1_force_od = bus_pins_active ? OD_MASK1 : '0;     // [R14]

  ppc_pad_ctrl #(.WIDTH(WIDTH)) u_pad0 (
    .out_value             (port0_periph_out),
    .analog_digital_select (port0_analog_digital_select_ff),
    .output_drive_select   (port0_output_drive_select_ff),
    .force_open_drain      (p0_force_od),
    .pin_level_raw         (p0_sync),
    .pad_out               (port0_pin_out),
    .pad_oe                (port0_pin_oe),
    .pad_pullup_en         (port0_pullup_en),
    .pad_rx_en             (port0_rx_en),
    .pin_level_dig         (p0_dig)
  );

  ppc_pad_ctrl #(.WIDTH(WIDTH)) u_pad1 (
    .out_value             (port1_data_latch_ff),
    .analog_digital_select (port1_analog_digital_select_ff),
    .output_drive_select   (port1_output_drive_select_ff),
    .force_open_drain      (p1_force_od),
    .pin_level_raw         (p1_sync),
    .pad_out               (port1_pin_out),
    .pad_oe                (port1_pin_oe),
    .pad_pullup_en         (port1_pullup_en),
    .pad_rx_en             (port1_rx_en),
    .pin_level_dig         (p1_dig)
  );

  assign port0_pin_level     = p0_dig;
  assign port0_crossbar_skip = port0_crossbar_bypass_ff;               // [R6]
endmodule

/* File: include/ppc_pkg.sv */
// Package: register map, reset values and widths for the port configuration block
package ppc_pkg;
  localparam int          PPC_W            = 8;
  localparam logic [7:0]  PPC_ADDR_P1DATA  = 8'h90;
  localparam logic [7:0]  PPC_ADDR_P0DRV   = 8'ha4;
  localparam logic [7:0]  PPC_ADDR_P1DRV   = 8'ha5;
  localparam logic [7:0]  PPC_ADDR_P0BYP   = 8'hd4;
  localparam logic [7:0]  PPC_ADDR_P0ANA   = 8'hf1;
  localparam logic [7:0]  PPC_ADDR_P1ANA   = 8'hf2;
  localparam logic [7:0]  PPC_CFG_PAGE     = 8'h0f;
  localparam logic [7:0]  PPC_RST_P1DATA   = 8'hff;
  localparam logic [7:0]  PPC_RST_DRV      = 8'h00;
  localparam logic [7:0]  PPC_RST_BYP      = 8'h00;
  localparam logic [7:0]  PPC_RST_ANA      = 8'hff;
  localparam logic [2:0]  PPC_BIT_IDX_POS  = 3'h0;
  localparam int          PPC_SYNC_STAGES  = 3;

  typedef enum logic [1:0] {
    PPC_ACC_BYTE,
    PPC_ACC_BIT,
    PPC_ACC_RMW
  } ppc_acc_t;
endpackage

/* File: rtl/ppc_pin_sync.sv */
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/100ps
module ppc_pin_sync
  import ppc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Pin levels in and filtered levels out
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] lvl_ff;
  wire  [WIDTH-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [WIDTH-1:0] nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);

  initial begin
    if (WIDTH < 1) $error("ppc_pin_sync: WIDTH must be positive");
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= '1;
      s2_ff  <= '1;
      s3_ff  <= '1;
      lvl_ff <= '1;
    end else begin
      s1_ff  <= pin_async;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign pin_level = lvl_ff;
endmodule

/* File: rtl/ppc_pad_ctrl.sv */
// Per-port pad control: analog gating, drive mode and output enables
`timescale 1ns/100ps
module ppc_pad_ctrl
  import ppc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Configuration
  input  wire logic [WIDTH-1:0] out_value,
  input  wire logic [WIDTH-1:0] analog_digital_select,
  input  wire logic [WIDTH-1:0] output_drive_select,
  input  wire logic [WIDTH-1:0] force_open_drain,
  input  wire logic [WIDTH-1:0] pin_level_raw,
  // Pad controls
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe,
  output logic      [WIDTH-1:0] pad_pullup_en,
  output logic      [WIDTH-1:0] pad_rx_en,
  output logic      [WIDTH-1:0] pin_level_dig
);
  wire [WIDTH-1:0] is_digital = analog_digital_select;                 // [R2]
  wire [WIDTH-1:0] push_pull  = output_drive_select & is_digital
                                & ~force_open_drain;                   // [R4] [R5] [R14]

  assign pad_out       = out_value;
  assign pad_oe        = push_pull | ~out_value;                       // [R15]
  assign pad_pullup_en = is_digital;                                   // [R1]
  assign pad_rx_en     = is_digital;                                   // [R1]
  assign pin_level_dig = pin_level_raw & is_digital;                   // [R9]
endmodule

/* File: tb/ppc_port_cfg_sva.sv */
// Checker: bus decode, latch and pad drive relations of the port block
`timescale 1ns/100ps
module ppc_port_cfg_sva
  import ppc_pkg::*;
#(
  parameter logic [7:0] OD_MASK1 = 8'h00
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Register bus
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic       sfr_bit_acc,
  input wire logic       sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic       bus_pins_active,
  // Pads
  input wire logic [7:0] port0_rx_en,
  input wire logic [7:0] port0_pin_level,
  input wire logic [7:0] port0_crossbar_skip,
  input wire logic [7:0] port1_pin_out,
  input wire logic [7:0] port1_pin_oe,
  input wire logic [7:0] port1_rx_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cfg_wr(a);
    sfr_wr && sfr_page == PPC_CFG_PAGE && sfr_addr == a;
  endsequence
  sequence s_data_wr;
    sfr_wr && sfr_addr == PPC_ADDR_P1DATA && !sfr_bit_acc;
  endsequence
  AST_OD_RELEASE: assert property ((~port1_pin_oe & ~port1_pin_out) == 8'h00)
    else $error("pad released while low");
  AST_ANA_IGNORE: assert property ((~port1_rx_en & (port1_pin_oe ^ ~port1_pin_out)) == 8'h00)
    else $error("analog pad not open-drain");
  AST_PP_DRIVE: assert property (s_cfg_wr(PPC_ADDR_P1DRV) |=>
    (~port1_pin_oe & port1_rx_en & $past(sfr_wdata) & ~(OD_MASK1 & {8{bus_pins_active}})) == 8'h00)
    else $error("push-pull pad not driven");
  AST_SKIP_LOAD: assert property (s_cfg_wr(PPC_ADDR_P0BYP) |=> port0_crossbar_skip == $past(sfr_wdata))
    else $error("skip bits not loaded");
  AST_LATCH_LOAD: assert property (s_data_wr |=> port1_pin_out == $past(sfr_wdata))
    else $error("latch not loaded");
  AST_RX_LEVEL: assert property ((port0_pin_level & ~port0_rx_en) == 8'h00)
    else $error("analog pin level seen");
  AST_PAGE_HIT: assert property (sfr_hit && sfr_addr != PPC_ADDR_P1DATA |-> sfr_page == PPC_CFG_PAGE)
    else $error("config hit off page");
  AST_RMW_LATCH: assert property (sfr_rd && sfr_rmw && !sfr_wr && sfr_addr == PPC_ADDR_P1DATA
    && !sfr_bit_acc |=> sfr_rdata == $past(port1_pin_out))
    else $error("rmw read not latch");
  AST_BUS_OD: assert property (bus_pins_active |-> (port1_pin_oe & port1_pin_out & OD_MASK1) == 8'h00)
    else $error("bus pin driven high");
endmodule

/* File: tb/ppc_pad_model.sv */
// Pad model: driven pins, weak pull-ups, external pull-downs, floating lines
`timescale 1ns/100ps
module ppc_pad_model (
  // Pad controls
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // Outside pull-down
  input  wire logic [7:0] ext_low,
  // Resolved level
  output logic      [7:0] pin_in
);
  // Released and unpulled pins float to the inverse value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_low & (pullup_en | ~pin_out));
endmodule

/* File: tb/test_port_pin_config_and_data.sv */
// Testbench: port configuration block with pad models
`timescale 1ns/100ps
module test_port_pin_config_and_data;
  import ppc_pkg::*;
  logic       sys_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic       sfr_bit_acc = 1'b0, sfr_rmw = 1'b0, bus_pins_active = 1'b0;
  logic [2:0] sfr_bit_idx = 3'h0;
  logic [7:0] sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, ext1 = 8'h00, d;
  logic [7:0] p0_per = 8'h96;
  wire  [7:0] sfr_rdata, p0_in, p0_out, p0_oe, p0_pu, p0_rx, p0_lvl, p0_skip;
  wire  [7:0] p1_in, p1_out, p1_oe, p1_pu, p1_rx;
  wire        sfr_hit;
  int         n_mismatch = 0, total_checks = 0;
  always #25 sys_clk = ~sys_clk;
  ppc_port_cfg #(.WIDTH(8), .OD_MASK0(8'h00), .OD_MASK1(8'h30)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_acc(sfr_bit_acc), .sfr_bit_idx(sfr_bit_idx),
    .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .bus_pins_active(bus_pins_active), .port0_pin_in(p0_in), .port0_periph_out(p0_per),
    .port0_pin_out(p0_out), .port0_pin_oe(p0_oe), .port0_pullup_en(p0_pu),
    .port0_rx_en(p0_rx), .port0_pin_level(p0_lvl), .port1_pin_in(p1_in),
    .port1_pin_out(p1_out), .port1_pin_oe(p1_oe), .port1_pullup_en(p1_pu),
    .port1_rx_en(p1_rx), .port0_crossbar_skip(p0_skip));
  ppc_pad_model u_pad0 (.pin_out(p0_out), .pin_oe(p0_oe), .pullup_en(p0_pu),
    .ext_low(8'h00), .pin_in(p0_in));
  ppc_pad_model u_pad1 (.pin_out(p1_out), .pin_oe(p1_oe), .pullup_en(p1_pu),
    .ext_low(ext1), .pin_in(p1_in));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic rd, input logic [7:0] pg,
                     input logic [7:0] ad, input logic [7:0] wd);
    sfr_wr = wr;
    sfr_rd = rd;
    sfr_page = pg;
    sfr_addr = ad;
    sfr_wdata = wd;
    @(posedge sys_clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_rmw = 1'b0;
    sfr_bit_acc = 1'b0;
    d = sfr_rdata;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset;
    logic [7:0] a[5] = '{PPC_ADDR_P0DRV, PPC_ADDR_P1DRV, PPC_ADDR_P0BYP, PPC_ADDR_P0ANA,
                         PPC_ADDR_P1ANA};
    logic [7:0] e[5] = '{PPC_RST_DRV, PPC_RST_DRV, PPC_RST_BYP, PPC_RST_ANA, PPC_RST_ANA};
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 1'b1, PPC_CFG_PAGE, a[i], 8'h00);
      check("reset_value", d, e[i]);
    end
    acc(1'b0, 1'b1, PPC_CFG_PAGE, 8'ha7, 8'h00);
    check("unmapped", d, 8'h00);
    check("latch_reset", p1_out, PPC_RST_P1DATA);
  endtask
  task automatic t_page;
    acc(1'b1, 1'b0, 8'h00, PPC_ADDR_P1DRV, 8'hff);
    acc(1'b0, 1'b1, PPC_CFG_PAGE, PPC_ADDR_P1DRV, 8'h00);
    check("off_page_write", d, 8'h00);
    sfr_page = 8'h00;
    #1;
    check("off_page_hit", {7'h00, sfr_hit}, 8'h00);
  endtask
  task automatic t_latch;
    acc(1'b1, 1'b0, 8'h00, PPC_ADDR_P1DATA, 8'h5b);
    check("latch", p1_out, 8'h5b);
    sfr_bit_acc = 1'b1;
    sfr_bit_idx = 3'h1;
    acc(1'b1, 1'b0, 8'h03, PPC_ADDR_P1DATA, 8'h00);
    check("bit_write", p1_out, 8'h59);
    check("open_drain_oe", p1_oe, 8'ha6);
    ext1 = 8'h01;
    settle();
    acc(1'b0, 1'b1, 8'h00, PPC_ADDR_P1DATA, 8'h00);
    check("pin_read", d, 8'h58);
    sfr_rmw = 1'b1;
    acc(1'b0, 1'b1, 8'h00, PPC_ADDR_P1DATA, 8'h00);
    check("rmw_read", d, 8'h59);
    sfr_bit_acc = 1'b1;
    sfr_bit_idx = 3'h3;
    acc(1'b0, 1'b1, 8'h05, PPC_ADDR_P1DATA, 8'h00);
    check("bit_read", d, 8'h01);
  endtask
  task automatic t_analog;
    acc(1'b1, 1'b0, PPC_CFG_PAGE, PPC_ADDR_P1ANA, 8'hf0);
    check("rx_en", p1_rx, 8'hf0);
    check("pullup_en", p1_pu, 8'hf0);
    acc(1'b1, 1'b0, PPC_CFG_PAGE, PPC_ADDR_P1DRV, 8'hff);
    check("push_pull_oe", p1_oe, 8'hf6);
    settle();
    acc(1'b0, 1'b1, 8'h00, PPC_ADDR_P1DATA, 8'h00);
    check("analog_read", d, 8'h50);
    bus_pins_active = 1'b1;
    #1;
    check("bus_pins_oe", p1_oe, 8'he6);
    bus_pins_active = 1'b0;
  endtask
  task automatic t_port0;
    acc(1'b1, 1'b0, PPC_CFG_PAGE, PPC_ADDR_P0BYP, 8'ha5);
    check("skip", p0_skip, 8'ha5);
    acc(1'b1, 1'b0, PPC_CFG_PAGE, PPC_ADDR_P0ANA, 8'h3c);
    check("p0_rx_en", p0_rx, 8'h3c);
    check("p0_pullup_en", p0_pu, 8'h3c);
    check("p0_pin_out", p0_out, 8'h96);
    check("p0_pin_oe", p0_oe, 8'h69);
    settle();
    check("p0_level", p0_lvl, 8'h14);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_page();
    t_latch();
    t_analog();
    t_port0();
    test_done();
  end
endmodule
bind ppc_port_cfg ppc_port_cfg_sva #(.OD_MASK1(OD_MASK1)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_acc(sfr_bit_acc), .sfr_rmw(sfr_rmw),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .bus_pins_active(bus_pins_active), .port0_rx_en(port0_rx_en),
  .port0_pin_level(port0_pin_level), .port0_crossbar_skip(port0_crossbar_skip),
  .port1_pin_out(port1_pin_out), .port1_pin_oe(port1_pin_oe), .port1_rx_en(port1_rx_en));
